/* rtl/ppc_pkg.sv */
// Shared constants, types and register map of the parallel port channel block.
// Assumes an APB master on pclk and external pins synchronous to pclk.
`default_nettype none
package ppc_pkg;
    localparam int DATA_W = 16;
    localparam int ADDR_W = 8;

    // Register byte offsets
    localparam logic [ADDR_W-1:0] OFS_CHAN_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_IFACE_CFG = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_IDLE_VAL = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_TX_A = 8'h0C;
    localparam logic [ADDR_W-1:0] OFS_TX_B = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_RX_A = 8'h14;
    localparam logic [ADDR_W-1:0] OFS_RX_B = 8'h18;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h1C;

    // Interface configuration field positions
    localparam int CFG_B_WAIT_POL = 18;
    localparam int CFG_B_ENA_POL = 17;
    localparam int CFG_B_START_POL = 16;
    localparam int CFG_A_IDLE_TRI = 13;
    localparam int CFG_A_CLK_INV = 12;
    localparam int CFG_A_DIV_LO = 8;
    localparam int CFG_A_WAIT_EN = 5;
    // Only implemented fields are writable; reserved bits stay zero
    localparam logic [31:0] CFG_WMASK = 32'h0007_3F20;

    // Channel control and status bit positions
    localparam int CTRL_A_TX = 0;
    localparam int CTRL_B_TX = 1;
    localparam int ST_A_BUSY = 0;
    localparam int ST_B_BUSY = 1;
    localparam int ST_A_RXV = 2;
    localparam int ST_B_RXV = 3;
    localparam int ST_A_START = 4;
    localparam int ST_B_START = 5;

    // Reset values and fixed channel B divisor
    localparam logic [31:0] RST_CFG = 32'h0000_0000;
    localparam logic [1:0] RST_CTRL = 2'h0;
    localparam logic [31:0] RST_IDLE = 32'h0000_0000;
    localparam logic [3:0] DIV_B = 4'h0;

    typedef enum logic [1:0] {
        TX_IDLE = 2'b00,
        TX_DRIVE = 2'b01,
        TX_HOLD = 2'b10
    } ppc_tx_state_type;

    // Pin levels driven by a channel; output enables are active low
    typedef struct packed {
        logic clk;
        logic start;
        logic enable;
        logic ctl_oe_n;
        logic wait_o;
        logic wait_oe_n;
        logic [DATA_W-1:0] data;
        logic data_oe_n;
    } ppc_chan_out_type;

    // Pin levels seen by a channel
    typedef struct packed {
        logic clk;
        logic start;
        logic enable;
        logic wait_i;
        logic [DATA_W-1:0] data;
    } ppc_chan_in_type;
endpackage
`default_nettype wire

/* rtl/ppc_clk_div.sv */
// Transmit port clock divider for one channel.
// Assumes run is a level in the pclk domain; clock rests low when stopped.
`default_nettype none
module ppc_clk_div
    import ppc_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Control
    input wire logic run,
    input wire logic [3:0] div,
    // Port clock and launch pulse at its falling edge
    output logic port_clk,
    output logic launch
);
    logic [3:0] cnt_r;
    logic clk_r;
    logic term;

    assign term = (cnt_r >= div);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_r <= 4'h0;
        end else if (!run || term) begin
            cnt_r <= 4'h0;
        end else begin
            cnt_r <= cnt_r + 4'h1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clk_r <= 1'b0;
        end else if (!run) begin
            clk_r <= 1'b0;
        end else if (term) begin
            clk_r <= ~clk_r;
        end
    end

    assign port_clk = clk_r;
    assign launch = run && term && clk_r;
endmodule
`default_nettype wire

/* rtl/ppc_port.sv */
// Two-channel parallel port: APB registers, channel transmit and receive.
// Assumes pins synchronous to pclk; tri-state resolved outside.
// Functional notes
// - Config bit 18 set makes channel B wait input active-low.
// - Config bit 17 set makes channel B enable strobe active-low.
// - Config bit 16 sets channel B start polarity; clear means active-high.
// - Start-polarity bit set means channel B start is active-low.
// - Config bits 15 to 14 are reserved and read zero.
// - Config bit 13 controls idle data pins, only in channel A transmit.
// - Bit 13 clear: idle transmitting A drives its idle value.
// - Bit 13 set: idle transmitting A tri-states its data pins.
// - Bit 12 clear: channel A works on the rising port clock edge.
// - Bit 12 set: channel A signals align to the falling edge.
// - Field 11 to 8 sets each channel A transmit clock phase to value plus one pclk cycles.
// - Channel A divisor applies only in transmit, ignored in receive.
// - Config bits 7 to 6 are reserved and read zero.
// - Bit 5 set makes transmitting A pause on wait; clear ignores wait.
`default_nettype none
module ppc_port
    import ppc_pkg::*;
#(
    parameter int DW = DATA_W
)(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Channel A pins
    input wire ppc_chan_in_type pin_a_in,
    output ppc_chan_out_type pin_a_out,
    // Channel B pins
    input wire ppc_chan_in_type pin_b_in,
    output ppc_chan_out_type pin_b_out
);
    logic [31:0] cfg_r;
    logic [1:0] ctrl_r;
    logic [31:0] idle_r;
    logic [DW-1:0] txa_data_r;
    logic [DW-1:0] txb_data_r;
    logic txa_pend_r;
    logic txb_pend_r;
    logic [DW-1:0] rxa_data_r;
    logic [DW-1:0] rxb_data_r;
    logic rxa_valid_r;
    logic rxb_valid_r;
    logic rxa_start_r;
    logic rxb_start_r;
    logic [31:0] prdata_r;
    logic rxa_clk_r;
    logic rxb_clk_r;
    ppc_tx_state_type txa_st_r;
    ppc_tx_state_type txb_st_r;
    logic txa_first_r;
    logic txb_first_r;
    logic [DW-1:0] txa_out_r;
    logic [DW-1:0] txb_out_r;

    logic wr_en;
    logic rd_setup;
    logic addr_hit;
    logic a_tx;
    logic b_tx;
    logic a_clk;
    logic a_launch;
    logic b_clk;
    logic b_launch;
    logic a_wait;
    logic b_wait;
    logic b_ena_in;
    logic b_start_in;
    logic a_rx_edge;
    logic b_rx_edge;
    logic txa_load;
    logic txb_load;
    logic txa_wr;
    logic txb_wr;
    logic st_wr;
    logic [DW-1:0] a_idle_val;

    function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
        is_mapped = (a == OFS_CHAN_CTRL) || (a == OFS_IFACE_CFG) || (a == OFS_IDLE_VAL) ||
                    (a == OFS_TX_A) || (a == OFS_TX_B) || (a == OFS_RX_A) ||
                    (a == OFS_RX_B) || (a == OFS_STATUS);
    endfunction

    // Next transmit state on a launch pulse
    function automatic ppc_tx_state_type tx_step(input ppc_tx_state_type st, input logic pend,
                                                 input logic stall);
        tx_step = st;
        unique case (st)
            TX_IDLE: begin
                if (pend && !stall) begin
                    tx_step = TX_DRIVE;
                end
            end
            TX_DRIVE: begin
                if (!pend) begin
                    tx_step = TX_IDLE;
                end else if (stall) begin
                    tx_step = TX_HOLD;
                end
            end
            TX_HOLD: begin
                if (!stall) begin
                    tx_step = pend ? TX_DRIVE : TX_IDLE;
                end
            end
            default: begin
                tx_step = TX_IDLE;
            end
        endcase
    endfunction

    // APB decode; zero wait states
    assign addr_hit = is_mapped(paddr);
    assign wr_en = psel && penable && pwrite && addr_hit;
    assign rd_setup = psel && !penable && !pwrite;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !addr_hit;
    assign prdata = prdata_r;

    assign a_tx = ctrl_r[CTRL_A_TX];
    assign b_tx = ctrl_r[CTRL_B_TX];
    assign txa_wr = wr_en && (paddr == OFS_TX_A);
    assign txb_wr = wr_en && (paddr == OFS_TX_B);
    assign st_wr = wr_en && (paddr == OFS_STATUS);
    assign a_idle_val = idle_r[DW-1:0];

    // Polarity applied at the pins; internal strobes are active high
    assign b_wait = pin_b_in.wait_i ^ cfg_r[CFG_B_WAIT_POL];
    assign b_ena_in = pin_b_in.enable ^ cfg_r[CFG_B_ENA_POL];
    assign b_start_in = pin_b_in.start ^ cfg_r[CFG_B_START_POL];
    assign a_wait = cfg_r[CFG_A_WAIT_EN] && pin_a_in.wait_i;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_r <= RST_CFG;
        end else if (wr_en && (paddr == OFS_IFACE_CFG)) begin
            cfg_r <= pwdata & CFG_WMASK;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r <= RST_CTRL;
            idle_r <= RST_IDLE;
        end else if (wr_en && (paddr == OFS_CHAN_CTRL)) begin
            ctrl_r <= pwdata[1:0];
        end else if (wr_en && (paddr == OFS_IDLE_VAL)) begin
            idle_r <= pwdata;
        end
    end

    // Transmit data; a write while pending is dropped
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            txa_data_r <= '0;
            txa_pend_r <= 1'b0;
        end else if (txa_wr && !txa_pend_r) begin
            txa_data_r <= pwdata[DW-1:0];
            txa_pend_r <= 1'b1;
        end else if (txa_load || !a_tx) begin
            txa_pend_r <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            txb_data_r <= '0;
            txb_pend_r <= 1'b0;
        end else if (txb_wr && !txb_pend_r) begin
            txb_data_r <= pwdata[DW-1:0];
            txb_pend_r <= 1'b1;
        end else if (txb_load || !b_tx) begin
            txb_pend_r <= 1'b0;
        end
    end

    // Read data registered in the setup cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r <= 32'h0000_0000;
        end else if (rd_setup) begin
            unique case (paddr)
                OFS_CHAN_CTRL: prdata_r <= {30'h0000_0000, ctrl_r};
                OFS_IFACE_CFG: prdata_r <= cfg_r;
                OFS_IDLE_VAL: prdata_r <= idle_r;
                OFS_TX_A: prdata_r <= 32'(txa_data_r);
                OFS_TX_B: prdata_r <= 32'(txb_data_r);
                OFS_RX_A: prdata_r <= 32'(rxa_data_r);
                OFS_RX_B: prdata_r <= 32'(rxb_data_r);
                OFS_STATUS: prdata_r <= {26'h000_0000, rxb_start_r, rxa_start_r, rxb_valid_r,
                                         rxa_valid_r, txb_pend_r || (txb_st_r != TX_IDLE),
                                         txa_pend_r || (txa_st_r != TX_IDLE)};
                default: prdata_r <= 32'h0000_0000;
            endcase
        end
    end

    // Transmit clocks; divider runs only in transmit
    ppc_clk_div u_div_a (
        .pclk(pclk),
        .presetn(presetn),
        .run(a_tx),
        .div(cfg_r[CFG_A_DIV_LO +: 4]),
        .port_clk(a_clk),
        .launch(a_launch)
    );

    ppc_clk_div u_div_b (
        .pclk(pclk),
        .presetn(presetn),
        .run(b_tx),
        .div(DIV_B),
        .port_clk(b_clk),
        .launch(b_launch)
    );

    assign txa_load = a_launch && txa_pend_r && !a_wait;
    assign txb_load = b_launch && txb_pend_r && !b_wait;

    // Channel A transmitter
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            txa_st_r <= TX_IDLE;
        end else if (!a_tx) begin
            txa_st_r <= TX_IDLE;
        end else if (a_launch) begin
            txa_st_r <= tx_step(txa_st_r, txa_pend_r, a_wait);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            txa_out_r <= '0;
            txa_first_r <= 1'b0;
        end else if (txa_load) begin
            txa_out_r <= txa_data_r;
            txa_first_r <= (txa_st_r == TX_IDLE);
        end else if (a_launch) begin
            txa_first_r <= 1'b0;
        end
    end

    // Channel B transmitter; wait always honoured
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            txb_st_r <= TX_IDLE;
        end else if (!b_tx) begin
            txb_st_r <= TX_IDLE;
        end else if (b_launch) begin
            txb_st_r <= tx_step(txb_st_r, txb_pend_r, b_wait);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            txb_out_r <= '0;
            txb_first_r <= 1'b0;
        end else if (txb_load) begin
            txb_out_r <= txb_data_r;
            txb_first_r <= (txb_st_r == TX_IDLE);
        end else if (b_launch) begin
            txb_first_r <= 1'b0;
        end
    end

    // Receive edge detection; A uses falling edge when inverted
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rxa_clk_r <= 1'b0;
            rxb_clk_r <= 1'b0;
        end else begin
            rxa_clk_r <= pin_a_in.clk;
            rxb_clk_r <= pin_b_in.clk;
        end
    end

    assign a_rx_edge = !a_tx && (cfg_r[CFG_A_CLK_INV] ? (rxa_clk_r && !pin_a_in.clk)
                                                      : (!rxa_clk_r && pin_a_in.clk));
    assign b_rx_edge = !b_tx && !rxb_clk_r && pin_b_in.clk;

    // Receive capture; capture beats a same-cycle clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rxa_data_r <= '0;
            rxa_valid_r <= 1'b0;
            rxa_start_r <= 1'b0;
        end else begin
            if (a_rx_edge && pin_a_in.enable) begin
                rxa_data_r <= pin_a_in.data;
                rxa_valid_r <= 1'b1;
            end else if (st_wr && pwdata[ST_A_RXV]) begin
                rxa_valid_r <= 1'b0;
            end
            if (a_rx_edge && pin_a_in.enable && pin_a_in.start) begin
                rxa_start_r <= 1'b1;
            end else if (st_wr && pwdata[ST_A_START]) begin
                rxa_start_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rxb_data_r <= '0;
            rxb_valid_r <= 1'b0;
            rxb_start_r <= 1'b0;
        end else begin
            if (b_rx_edge && b_ena_in) begin
                rxb_data_r <= pin_b_in.data;
                rxb_valid_r <= 1'b1;
            end else if (st_wr && pwdata[ST_B_RXV]) begin
                rxb_valid_r <= 1'b0;
            end
            if (b_rx_edge && b_ena_in && b_start_in) begin
                rxb_start_r <= 1'b1;
            end else if (st_wr && pwdata[ST_B_START]) begin
                rxb_start_r <= 1'b0;
            end
        end
    end

    // Channel A pins
    always_comb begin
        pin_a_out.clk = a_tx ? (a_clk ^ cfg_r[CFG_A_CLK_INV]) : 1'b0;
        pin_a_out.start = a_tx && (txa_st_r == TX_DRIVE) && txa_first_r;
        pin_a_out.enable = a_tx && (txa_st_r == TX_DRIVE);
        pin_a_out.ctl_oe_n = !a_tx;
        pin_a_out.wait_o = 1'b0;
        pin_a_out.wait_oe_n = a_tx;
        pin_a_out.data = '0;
        pin_a_out.data_oe_n = 1'b1;
        if (a_tx) begin
            if (txa_st_r != TX_IDLE) begin
                pin_a_out.data = txa_out_r;
                pin_a_out.data_oe_n = 1'b0;
            end else if (!cfg_r[CFG_A_IDLE_TRI]) begin
                pin_a_out.data = a_idle_val;
                pin_a_out.data_oe_n = 1'b0;
            end else begin
                pin_a_out.data_oe_n = 1'b1;
            end
        end
    end

    // Channel B pins, polarity applied on the way out
    always_comb begin
        pin_b_out.clk = b_tx && b_clk;
        pin_b_out.start = (b_tx && (txb_st_r == TX_DRIVE) && txb_first_r) ^ cfg_r[CFG_B_START_POL];
        pin_b_out.enable = (b_tx && (txb_st_r == TX_DRIVE)) ^ cfg_r[CFG_B_ENA_POL];
        pin_b_out.ctl_oe_n = !b_tx;
        pin_b_out.wait_o = 1'b0;
        pin_b_out.wait_oe_n = b_tx;
        pin_b_out.data = (b_tx && txb_st_r != TX_IDLE) ? txb_out_r : idle_r[31 -: DW];
        pin_b_out.data_oe_n = !b_tx;
    end
endmodule
`default_nettype wire

/* dv/ppc_port_chk.sv */
// Concurrent checks on the port block's top-level ports.
// Assumes the register map of ppc_pkg; bound into ppc_port.
`default_nettype none
module ppc_port_chk
    import ppc_pkg::*;
#(
    parameter int DW = DATA_W
)(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Channel pins
    input wire ppc_chan_in_type pin_a_in,
    input wire ppc_chan_out_type pin_a_out,
    input wire ppc_chan_in_type pin_b_in,
    input wire ppc_chan_out_type pin_b_out
);
    logic [31:0] cfg_r;
    logic [1:0] ctrl_r;
    logic wr;
    int hi_cnt;
    int wt_cnt;
    assign wr = psel && penable && pwrite && pready;

    // Mode and config shadow
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_r <= 32'h0;
            ctrl_r <= 2'h0;
        end else begin
            if (wr && paddr == OFS_IFACE_CFG) cfg_r <= pwdata & CFG_WMASK;
            if (wr && paddr == OFS_CHAN_CTRL) ctrl_r <= pwdata[1:0];
        end
    end

    // Clock high length, spoiled by config writes; wait run
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hi_cnt <= 0;
            wt_cnt <= 0;
        end else begin
            hi_cnt <= (wr && paddr == OFS_IFACE_CFG) ? -100 : (pin_a_out.clk ? hi_cnt + 1 : 0);
            wt_cnt <= (ctrl_r[CTRL_A_TX] && cfg_r[CFG_A_WAIT_EN] && pin_a_in.wait_i) ? wt_cnt + 1 : 0;
        end
    end

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence s_cfg_rd;
        psel && penable && !pwrite && paddr == OFS_IFACE_CFG;
    endsequence
    sequence s_a_rx_steady;
        !ctrl_r[CTRL_A_TX] && !$past(ctrl_r[CTRL_A_TX]) && $stable(cfg_r);
    endsequence

    AST_CFG_RSV: assert property (s_cfg_rd |-> (prdata & ~CFG_WMASK) == 32'h0)
        else $error("reserved cfg bits set");
    AST_RX_WAIT: assert property (!ctrl_r[CTRL_A_TX] |-> !pin_a_out.wait_o && !pin_a_out.wait_oe_n)
        else $error("A rx wait not low");
    AST_RX_HIZ: assert property (!ctrl_r[CTRL_A_TX] |-> pin_a_out.data_oe_n)
        else $error("A rx drives data");
    AST_IDLE_DRV: assert property (ctrl_r[CTRL_A_TX] && !cfg_r[CFG_A_IDLE_TRI] |-> !pin_a_out.data_oe_n)
        else $error("A tx released data");
    AST_B_POL: assert property (!ctrl_r[CTRL_B_TX] |-> pin_b_out.enable == cfg_r[CFG_B_ENA_POL]
        && pin_b_out.start == cfg_r[CFG_B_START_POL])
        else $error("B strobe rest level");
    AST_RX_CLK: assert property (s_a_rx_steady |-> $stable(pin_a_out.clk))
        else $error("A clock toggles in rx");
    AST_HI_TIME: assert property (ctrl_r[CTRL_A_TX] && !cfg_r[CFG_A_CLK_INV] && $fell(pin_a_out.clk)
        && hi_cnt > 0 |-> hi_cnt == int'(cfg_r[11:8]) + 1)
        else $error("A clock high phase");
    AST_WAIT_HOLD: assert property (wt_cnt >= 40 |-> !pin_a_out.enable)
        else $error("A sends during wait");
endmodule

bind ppc_port ppc_port_chk #(.DW(DW)) ppc_port_chk_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .pin_a_in(pin_a_in),
    .pin_a_out(pin_a_out), .pin_b_in(pin_b_in), .pin_b_out(pin_b_out)
);
`default_nettype wire

/* dv/ppc_far_end.sv */
// Far-side model: drives channel inputs, captures sent words.
// Assumes the bench steers wait, strobes and polarity.
`default_nettype none
module ppc_far_end
    import ppc_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Block pins
    input wire ppc_chan_out_type pin_a_out,
    input wire ppc_chan_out_type pin_b_out,
    output var ppc_chan_in_type pin_a_in,
    output var ppc_chan_in_type pin_b_in,
    // Bench controls, polarity as wait, enable, start
    input wire logic a_wait,
    input wire logic a_inv,
    input wire logic [2:0] b_pol,
    input wire logic b_wait,
    input wire logic b_run,
    input wire logic b_act,
    input wire logic [DATA_W-1:0] b_data,
    // Observations
    output logic [DATA_W-1:0] a_word,
    output var int a_words,
    output var int a_hi,
    output var int b_words
);
    logic a_clk_q;
    logic b_clk_q;
    logic [1:0] b_div;
    int a_hcnt;

    always_comb begin
        pin_a_in = '0;
        pin_a_in.wait_i = a_wait;
        pin_a_in.data = ~pin_a_out.data;
        pin_b_in.clk = b_div[1];
        pin_b_in.start = b_act ^ b_pol[0];
        pin_b_in.enable = b_act ^ b_pol[1];
        pin_b_in.wait_i = b_wait ^ b_pol[2];
        pin_b_in.data = b_act ? b_data : ~b_data;
    end

    // Channel B clock stands still outside frames
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            b_div <= 2'h0;
        end else if (b_run) begin
            b_div <= b_div + 2'h1;
        end
    end

    // Samples A on the active pin clock edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            a_clk_q <= 1'b0;
            a_hcnt <= 0;
            a_hi <= 0;
            a_words <= 0;
            a_word <= '0;
            b_clk_q <= 1'b0;
            b_words <= 0;
        end else begin
            a_clk_q <= pin_a_out.clk;
            b_clk_q <= pin_b_out.clk;
            a_hcnt <= pin_a_out.clk ? a_hcnt + 1 : 0;
            if (!pin_a_out.clk && a_clk_q) a_hi <= a_hcnt;
            if (pin_a_out.enable && !pin_a_out.data_oe_n && pin_a_out.clk != a_clk_q && (pin_a_out.clk ^ a_inv)) begin
                a_word <= pin_a_out.data;
                a_words <= a_words + 1;
            end
            if (pin_b_out.clk && !b_clk_q && (pin_b_out.enable ^ b_pol[1])) b_words <= b_words + 1;
        end
    end
endmodule
`default_nettype wire

/* dv/ppc_port_tb.sv */
// Self-checking bench for the parallel port block.
// Assumes the register map of ppc_pkg.
`default_nettype none
module ppc_port_tb
    import ppc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int LIMIT = 20000;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic a_wait, a_inv, b_wait, b_run, b_act;
    logic [ADDR_W-1:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [2:0] b_pol;
    logic [DATA_W-1:0] b_data, a_word;
    int a_words, a_hi, b_words, cycles, n_mismatch, n_checks;
    ppc_chan_in_type pin_a_in, pin_b_in;
    ppc_chan_out_type pin_a_out, pin_b_out;

    ppc_port ppc_port_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .pin_a_in(pin_a_in), .pin_a_out(pin_a_out), .pin_b_in(pin_b_in), .pin_b_out(pin_b_out));
    ppc_far_end ppc_far_end_inst (.pclk(pclk), .presetn(presetn), .pin_a_out(pin_a_out), .pin_b_out(pin_b_out),
        .pin_a_in(pin_a_in), .pin_b_in(pin_b_in), .a_wait(a_wait), .a_inv(a_inv), .b_pol(b_pol), .b_wait(b_wait),
        .b_run(b_run), .b_act(b_act), .b_data(b_data), .a_word(a_word), .a_words(a_words), .a_hi(a_hi),
        .b_words(b_words));

    always #12.5 pclk = ~pclk;

    task automatic complete_run();
        $display("Checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    always @(posedge pclk) begin
        cycles++;
        if (cycles == LIMIT) begin
            n_mismatch++;
            complete_run();
        end
    end

    task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d = 32'h0);
        int t = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            t++;
        end while (pready !== 1'b1 && t < 50);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic send_a(input logic [15:0] w);
        int n0 = a_words;
        apb(1'b1, OFS_TX_A, {16'h0000, w});
        for (int i = 0; i < 200 && a_words == n0; i++) @(posedge pclk);
        repeat (40) @(posedge pclk);
    endtask

    task automatic t_regs();
        apb(1'b0, OFS_IFACE_CFG);
        chk("cfg reset", 32'h0, rd);
        apb(1'b1, OFS_IFACE_CFG, 32'hFFFF_FFFF);
        apb(1'b0, OFS_IFACE_CFG);
        chk("cfg reserved", 32'h7_3F20, rd);
        apb(1'b0, 8'h40);
        chk("unmapped error", 32'h1, 32'(err));
        apb(1'b1, OFS_IFACE_CFG, 32'h0);
    endtask

    task automatic t_idle();
        apb(1'b1, OFS_IDLE_VAL, 32'h5A5A_C3A5);
        apb(1'b1, OFS_CHAN_CTRL, 32'h1);
        repeat (2) @(posedge pclk);
        chk("idle drive", 32'hC3A5, {15'h0, pin_a_out.data_oe_n, pin_a_out.data});
        apb(1'b1, OFS_IFACE_CFG, 32'h2000);
        repeat (2) @(posedge pclk);
        chk("idle tristate", 32'h1, 32'(pin_a_out.data_oe_n));
        apb(1'b1, OFS_CHAN_CTRL, 32'h0);
        apb(1'b1, OFS_IFACE_CFG, 32'h0);
        repeat (2) @(posedge pclk);
        chk("rx released", 32'h1, 32'(pin_a_out.data_oe_n));
        chk("rx wait low", 32'h0, {30'h0, pin_a_out.wait_o, pin_a_out.wait_oe_n});
    endtask

    task automatic t_clk();
        logic [31:0] cv [4] = '{32'h0, 32'h300, 32'hF00, 32'h1100};
        apb(1'b1, OFS_CHAN_CTRL, 32'h1);
        foreach (cv[i]) begin
            apb(1'b1, OFS_IFACE_CFG, cv[i]);
            a_inv <= cv[i][12];
            send_a(16'h1230 + 16'(i));
            chk("tx word", 32'h1230 + i, 32'(a_word));
            if (!cv[i][12]) chk("clock high", {28'h0, cv[i][11:8]} + 32'h1, a_hi);
        end
        a_inv <= 1'b0;
    endtask

    task automatic t_wait();
        int n0 = a_words;
        apb(1'b1, OFS_IFACE_CFG, 32'h20);
        a_wait <= 1'b1;
        apb(1'b1, OFS_TX_A, 32'hF0F);
        repeat (60) @(posedge pclk);
        chk("held by wait", n0, a_words);
        a_wait <= 1'b0;
        repeat (40) @(posedge pclk);
        chk("sent after wait", 32'hF0F, 32'(a_word));
        apb(1'b1, OFS_IFACE_CFG, 32'h0);
        a_wait <= 1'b1;
        send_a(16'hF0F0);
        chk("wait ignored", 32'hF0F0, 32'(a_word));
        a_wait <= 1'b0;
        apb(1'b1, OFS_CHAN_CTRL, 32'h0);
    endtask

    task automatic t_chan_b();
        int n0;
        for (int p = 0; p < 2; p++) begin
            apb(1'b1, OFS_CHAN_CTRL, 32'h0);
            apb(1'b1, OFS_IFACE_CFG, {13'h0, {3{p[0]}}, 16'h0});
            b_pol <= {3{p[0]}};
            b_data <= {15'h3600, p[0]};
            apb(1'b1, OFS_STATUS, 32'h3C);
            b_run <= 1'b1;
            repeat (20) @(posedge pclk);
            apb(1'b0, OFS_STATUS);
            chk("b quiet", 32'h0, rd & 32'h28);
            b_act <= 1'b1;
            repeat (20) @(posedge pclk);
            b_act <= 1'b0;
            b_run <= 1'b0;
            apb(1'b0, OFS_STATUS);
            chk("b start and valid", 32'h28, rd & 32'h28);
            apb(1'b0, OFS_RX_B);
            chk("b rx data", 32'(b_data), rd);
            apb(1'b1, OFS_CHAN_CTRL, 32'h2);
            apb(1'b1, OFS_IFACE_CFG, {13'h0, p[0], 18'h0});
            b_pol <= {p[0], 2'b00};
            b_wait <= 1'b1;
            n0 = b_words;
            apb(1'b1, OFS_TX_B, 32'h7700);
            repeat (40) @(posedge pclk);
            chk("b held by wait", n0, b_words);
            b_wait <= 1'b0;
            repeat (40) @(posedge pclk);
            chk("b sent", n0 + 1, b_words);
        end
    endtask

    initial begin
        pclk = 1'b0;
        presetn = 1'b0;
        {psel, penable, pwrite, a_wait, a_inv, b_wait, b_run, b_act} = 8'h00;
        paddr = '0;
        pwdata = '0;
        b_pol = 3'h0;
        b_data = '0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_idle();
        t_clk();
        t_wait();
        t_chan_b();
        complete_run();
    end
endmodule
`default_nettype wire
